/* core/bcd_alu_pkg.sv */
// Shared types and constants for the BCD, inc/dec and power-down unit
package bcd_alu_pkg;

  // ==========================================================
  // Avalon-MM slave carrier
  // ==========================================================
  localparam int AV_AW = 8;           // Byte address width
  localparam int AV_DW = 32;          // Data width
  localparam int AV_BE = AV_DW / 8;   // Byte enables

  typedef struct packed {
    logic             read;           // Read request
    logic             write;          // Write request
    logic [AV_AW-1:0] address;        // Byte address
    logic [AV_DW-1:0] writedata;      // Write data
    logic [AV_BE-1:0] byteenable;     // Byte lanes
  } av_req_t;

  typedef struct packed {
    logic [AV_DW-1:0] readdata;       // Read data
    logic             waitrequest;    // Stall the master
  } av_rsp_t;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [AV_AW-1:0] ADDR_CMD  = 8'h00; // Command / last
  localparam logic [AV_AW-1:0] ADDR_WREG = 8'h04; // Working register
  localparam logic [AV_AW-1:0] ADDR_STAT = 8'h08; // Status flags
  localparam logic [AV_AW-1:0] ADDR_WAKE = 8'h0C; // Wake-up strobe
  localparam logic [AV_AW-1:0] ADDR_WDOG = 8'h10; // Watchdog state
  localparam logic [AV_AW-1:0] ADDR_MEM  = 8'h40; // Memory window

  localparam int MEM_IDX_LSB = 2;     // One byte per word
  localparam int REG_W       = 8;     // Data byte width
  localparam int CMD_OP_LSB  = 0;     // Command opcode field
  localparam int CMD_OP_W    = 3;
  localparam int CMD_ADR_LSB = 4;     // Command address field
  localparam int CMD_ADR_W   = 4;
  localparam int LANE0       = 0;     // Byte lane for all regs

  // ==========================================================
  // Arithmetic constants
  // ==========================================================
  localparam logic [3:0]       BCD_NIB_MAX = 4'h9;
  localparam logic [REG_W-1:0] BCD_ADJ_LO  = 8'h06;
  localparam logic [REG_W-1:0] BCD_ADJ_HI  = 8'h60;
  localparam logic [REG_W-1:0] BYTE_ONE    = 8'h01;
  localparam logic [REG_W-1:0] BYTE_ZERO   = 8'h00;

  // ==========================================================
  // Operations, flags, results
  // ==========================================================
  typedef enum logic [CMD_OP_W-1:0] {
    op_none,
    op_invert_memory_into_working_reg,
    op_bcd_fixup_to_memory,
    op_memory_minus_one,
    op_memory_minus_one_to_working_reg,
    op_memory_plus_one,
    op_memory_plus_one_to_working_reg,
    op_power_down
  } op_t;

  // Bit order equals the status register layout, bit 0 = zero
  typedef struct packed {
    logic halted;                     // Core clock stopped
    logic wdx;                        // Watchdog expired flag
    logic slp;                        // Sleep entered flag
    logic lnc;                        // Low nibble carry
    logic c;                          // Carry
    logic z;                          // Zero
  } flags_t;

  typedef struct packed {
    logic [REG_W-1:0] value;          // Result byte
    logic             to_mem;         // Write result to memory
    logic             to_wreg;        // Write result to working reg
    logic             upd_z;          // Update zero flag
    logic             z;              // New zero flag
    logic             upd_c;          // Update carry flag
    logic             c;              // New carry flag
    logic             sleep;          // Enter power-down
  } alu_out_t;

endpackage

/* core/bcd_alu.sv */
// Combinational evaluation of one operation on a memory byte
`timescale 1ns/10ps
`default_nettype none

module bcd_alu
  import bcd_alu_pkg::*;
(
  input  wire op_t              op,          // Operation to evaluate
  input  wire logic [REG_W-1:0] mem_byte,    // Addressed memory byte
  input  wire logic [REG_W-1:0] working_reg, // Working register
  input  wire flags_t           flg,         // Flags before the op
  output var  alu_out_t         res          // Result and targets
);

  // ==========================================================
  // Decimal correction terms
  // ==========================================================
  logic       lo_fix;                 // Low nibble needs +6
  logic       hi_fix;                 // High nibble needs +6
  logic [8:0] bcd_sum;                // Corrected sum with carry out

  // Operation decode; nibble tests look at the uncorrected value
  always_comb begin
    res     = '0;
    lo_fix  = (working_reg[3:0] > BCD_NIB_MAX) || flg.lnc;
    hi_fix  = (working_reg[7:4] > BCD_NIB_MAX) || flg.c;
    bcd_sum = {1'b0, working_reg}
            + {1'b0, (hi_fix ? BCD_ADJ_HI : BYTE_ZERO)
                   | (lo_fix ? BCD_ADJ_LO : BYTE_ZERO)};
    case (op)
      op_invert_memory_into_working_reg: begin
        res.value   = ~mem_byte;
        res.to_wreg = 1'b1;
        res.upd_z   = 1'b1;
      end
      op_bcd_fixup_to_memory: begin
        res.value  = bcd_sum[7:0];
        res.to_mem = 1'b1;
        // Carry only ever rises here so decimal chains work
        res.upd_c  = 1'b1;
        res.c      = flg.c | hi_fix | bcd_sum[8];
      end
      op_memory_minus_one: begin
        res.value  = mem_byte - BYTE_ONE;
        res.to_mem = 1'b1;
        res.upd_z  = 1'b1;
      end
      op_memory_minus_one_to_working_reg: begin
        res.value   = mem_byte - BYTE_ONE;
        res.to_wreg = 1'b1;
        res.upd_z   = 1'b1;
      end
      op_memory_plus_one: begin
        res.value  = mem_byte + BYTE_ONE;
        res.to_mem = 1'b1;
        res.upd_z  = 1'b1;
      end
      op_memory_plus_one_to_working_reg: begin
        res.value   = mem_byte + BYTE_ONE;
        res.to_wreg = 1'b1;
        res.upd_z   = 1'b1;
      end
      op_power_down: begin
        res.sleep = 1'b1;
      end
      default: begin
        res.sleep = 1'b0;
      end
    endcase
    // Byte arithmetic wraps, zero tested on all eight bits
    res.z = (res.value == BYTE_ZERO);
  end

endmodule

`default_nettype wire

/* core/incdec_bcd_unit.sv */
// Top of the execution unit: register bus, data memory, flags, watchdog
//
// Behaviour
// - Invert memory byte into working register, zero only
// - Low nibble over nine or low nibble carry: add six
// - High nibble over nine or carry: add six
// - Decimal fixup result goes to memory byte
// - Decimal fixup touches carry only, sets on overflow
// - Memory byte minus one, back to memory
// - Memory byte minus one into working register
// - Memory byte plus one, back to memory
// - Memory byte plus one into working register
// - Power-down stops execution and the clock
// - Power-down keeps memory and working register intact
// - Power-down clears watchdog count and prescaler
// - Power-down sets sleep flag, clears expired flag
`timescale 1ns/10ps
`default_nettype none

module incdec_bcd_unit
  import bcd_alu_pkg::*;
#(
  parameter int MEM_DEPTH = 16,       // Data memory bytes
  parameter int WDOG_PRE_W = 8,       // Watchdog prescaler width
  parameter int WDOG_CNT_W = 8        // Watchdog count width
)(
  input  wire logic             clk,         // 100 MHz core clock
  input  wire logic             nrst,        // Sync reset, active low
  input  wire av_req_t          av_req,      // Avalon-MM request
  output var  av_rsp_t          av_rsp,      // Avalon-MM response
  output var  logic             sys_clk_en,  // System clock running
  output var  logic [REG_W-1:0] working_reg, // Working register
  output var  flags_t           status       // Flag bits
);

  // ==========================================================
  // Parameter checks
  // ==========================================================
  // Memory is addressed by the 4-bit command field and must fit
  // in the bus window below the top of the byte address range.
  if (MEM_DEPTH < 1 || MEM_DEPTH > (1 << CMD_ADR_W)) begin : g_bad
    $error("MEM_DEPTH out of range");
  end
  if (WDOG_PRE_W < 1 || WDOG_CNT_W < 1
      || WDOG_PRE_W + WDOG_CNT_W > AV_DW) begin : g_badw
    $error("watchdog widths out of range");
  end

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [MEM_DEPTH-1:0][REG_W-1:0] mem;    // Data memory
    logic [REG_W-1:0]                wreg;   // Working register
    flags_t                          flg;    // Flags and halt
    logic [REG_W-1:0]                cmd;    // Last command taken
    logic [WDOG_PRE_W-1:0]           pre;    // Watchdog prescaler
    logic [WDOG_CNT_W-1:0]           cnt;    // Watchdog count
    logic                            ack;    // Answer cycle
    logic [AV_DW-1:0]                rdata;  // Read data
  } state_t;

  localparam state_t ST_RST = '0;            // Everything cleared

  state_t st_ff;                             // Registered state
  state_t nxt_st;                            // Next state

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic                 bus_pend;   // Read or write pending
  logic                 wr_take;    // Write takes effect now
  logic                 lane_ok;    // Byte lane 0 enabled
  logic [AV_AW-1:0]     moff;       // Offset into memory window
  logic [CMD_ADR_W-1:0] mem_idx;    // Memory word index
  logic                 mem_hit;    // Access falls in memory
  logic [REG_W-1:0]     wbyte;      // Write data, lane 0
  logic [AV_DW-1:0]     rd_val;     // Value to return on read

  assign bus_pend = av_req.read | av_req.write;
  assign wr_take = av_req.write & st_ff.ack;
  assign lane_ok = av_req.byteenable[LANE0];
  assign moff    = av_req.address - ADDR_MEM;
  assign mem_idx = moff[MEM_IDX_LSB +: CMD_ADR_W];
  assign wbyte   = av_req.writedata[REG_W-1:0];
  assign mem_hit = (av_req.address >= ADDR_MEM)
                && (moff[MEM_IDX_LSB-1:0] == '0)
                && (int'(moff[AV_AW-1:MEM_IDX_LSB]) < MEM_DEPTH);

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_val = '0;
    if (mem_hit) begin
      rd_val[REG_W-1:0] = st_ff.mem[mem_idx];
    end else begin
      case (av_req.address)
        ADDR_CMD:  rd_val[REG_W-1:0] = st_ff.cmd;
        ADDR_WREG: rd_val[REG_W-1:0] = st_ff.wreg;
        ADDR_STAT: rd_val[$bits(flags_t)-1:0] = st_ff.flg;
        ADDR_WDOG: rd_val[WDOG_PRE_W+WDOG_CNT_W-1:0] =
                     {st_ff.cnt, st_ff.pre};
        default:   rd_val = '0;
      endcase
    end
  end

  // ==========================================================
  // Command decode and evaluation
  // ==========================================================
  logic                 exec_go;    // Command executes this edge
  op_t                  exec_op;    // Requested operation
  logic [CMD_ADR_W-1:0] exec_adr;   // Requested memory byte
  logic                 adr_ok;     // Address inside memory
  logic [REG_W-1:0]     sel_byte;   // Addressed memory byte
  alu_out_t             res;        // Evaluation result

  // A halted core takes no command: the clock is notionally off
  assign exec_go  = wr_take && lane_ok && !mem_hit
                 && (av_req.address == ADDR_CMD)
                 && !st_ff.flg.halted;
  assign exec_op  = op_t'(wbyte[CMD_OP_LSB +: CMD_OP_W]);
  assign exec_adr = wbyte[CMD_ADR_LSB +: CMD_ADR_W];
  assign adr_ok   = int'(exec_adr) < MEM_DEPTH;
  assign sel_byte = adr_ok ? st_ff.mem[exec_adr] : BYTE_ZERO;

  bcd_alu u_alu (
    .op          (exec_op),
    .mem_byte    (sel_byte),
    .working_reg (st_ff.wreg),
    .flg         (st_ff.flg),
    .res         (res)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  // Order matters: bus writes first, then watchdog events so a
  // hardware set beats a software clear, then the command.
  always_comb begin
    nxt_st     = st_ff;
    // One wait state per access, then the answer cycle
    nxt_st.ack = bus_pend & ~st_ff.ack;
    if (av_req.read && !st_ff.ack) begin
      nxt_st.rdata = rd_val;
    end
    // Plain register and memory writes
    if (wr_take && lane_ok) begin
      if (mem_hit) begin
        nxt_st.mem[mem_idx] = wbyte;
      end else begin
        case (av_req.address)
          ADDR_WREG: nxt_st.wreg = wbyte;
          ADDR_STAT: begin
            // Halt bit is read-only; wake goes through ADDR_WAKE
            nxt_st.flg.z   = wbyte[0];
            nxt_st.flg.c   = wbyte[1];
            nxt_st.flg.lnc = wbyte[2];
            nxt_st.flg.slp = wbyte[3];
            nxt_st.flg.wdx = wbyte[4];
          end
          ADDR_WAKE: nxt_st.flg.halted = 1'b0;
          default:   nxt_st.flg.halted = st_ff.flg.halted;
        endcase
      end
    end
    // Watchdog ticks only while the core clock runs
    if (!st_ff.flg.halted) begin
      nxt_st.pre = st_ff.pre + 1'b1;
      if (&st_ff.pre) begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
        if (&st_ff.cnt) begin
          nxt_st.flg.wdx = 1'b1;
        end
      end
    end
    // Command execution in a single cycle
    if (exec_go) begin
      nxt_st.cmd = wbyte;
      if (adr_ok) begin
        if (res.to_mem) begin
          nxt_st.mem[exec_adr] = res.value;
        end
        if (res.to_wreg) begin
          nxt_st.wreg = res.value;
        end
        if (res.upd_z) begin
          nxt_st.flg.z = res.z;
        end
        if (res.upd_c) begin
          nxt_st.flg.c = res.c;
        end
      end
      // Power-down needs no memory byte; data stays as it is
      if (res.sleep) begin
        nxt_st.flg.halted = 1'b1;
        nxt_st.pre        = '0;
        nxt_st.cnt        = '0;
        nxt_st.flg.slp    = 1'b1;
        nxt_st.flg.wdx    = 1'b0;
      end
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Waitrequest is combinational so the answer edge is fixed
  assign av_rsp.waitrequest = bus_pend & ~st_ff.ack;
  assign av_rsp.readdata    = st_ff.rdata;
  assign sys_clk_en         = ~st_ff.flg.halted;
  assign working_reg        = st_ff.wreg;
  assign status             = st_ff.flg;

  // ==========================================================
  // Checks
  // ==========================================================
  logic [REG_W-1:0] cur_byte;       // Byte named by last command
  logic [REG_W-1:0] bcd_adj;        // Expected decimal correction
  logic             is_zop;         // Op that updates zero flag

  assign cur_byte = (int'(st_ff.cmd[CMD_ADR_LSB +: CMD_ADR_W])
                     < MEM_DEPTH)
                  ? st_ff.mem[st_ff.cmd[CMD_ADR_LSB +: CMD_ADR_W]]
                  : BYTE_ZERO;
  assign bcd_adj  = ((st_ff.wreg[7:4] > BCD_NIB_MAX || st_ff.flg.c)
                     ? BCD_ADJ_HI : BYTE_ZERO)
                  | ((st_ff.wreg[3:0] > BCD_NIB_MAX || st_ff.flg.lnc)
                     ? BCD_ADJ_LO : BYTE_ZERO);
  assign is_zop   = exec_go && adr_ok
                 && exec_op != op_bcd_fixup_to_memory
                 && exec_op != op_power_down && exec_op != op_none;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_invert_wreg: assert property (
    exec_go && adr_ok && exec_op == op_invert_memory_into_working_reg
    |=> st_ff.wreg == ~cur_byte && cur_byte == $past(sel_byte))
    else $error("invert result or memory wrong");

  chk_bcd_low: assert property (
    exec_go && adr_ok && exec_op == op_bcd_fixup_to_memory
    |=> cur_byte[3:0] == 4'($past(st_ff.wreg[3:0])
        + (($past(st_ff.wreg[3:0]) > BCD_NIB_MAX || $past(st_ff.flg.lnc))
           ? 4'h6 : 4'h0)))
    else $error("low nibble correction wrong");

  chk_bcd_store: assert property (
    exec_go && adr_ok && exec_op == op_bcd_fixup_to_memory
    |=> cur_byte == REG_W'($past(st_ff.wreg) + $past(bcd_adj))
        && $stable(st_ff.wreg))
    else $error("decimal fixup store wrong");

  chk_bcd_flags: assert property (
    exec_go && adr_ok && exec_op == op_bcd_fixup_to_memory
    |=> $stable(st_ff.flg.z) && $stable(st_ff.flg.lnc)
        && st_ff.flg.c == ($past(st_ff.flg.c) || $past(bcd_adj[5])))
    else $error("decimal fixup touched other flags");

  chk_minus_mem: assert property (
    exec_go && adr_ok && exec_op == op_memory_minus_one
    |=> cur_byte == REG_W'($past(sel_byte) - BYTE_ONE))
    else $error("memory decrement wrong");

  chk_minus_wreg: assert property (
    exec_go && adr_ok && exec_op == op_memory_minus_one_to_working_reg
    |=> st_ff.wreg == REG_W'($past(sel_byte) - BYTE_ONE)
        && cur_byte == $past(sel_byte))
    else $error("decrement to working register wrong");

  chk_inc_mem: assert property (
    exec_go && adr_ok && exec_op == op_memory_plus_one
    |=> cur_byte == REG_W'($past(sel_byte) + BYTE_ONE))
    else $error("memory increment wrong");

  chk_inc_wreg: assert property (
    exec_go && adr_ok && exec_op == op_memory_plus_one_to_working_reg
    |=> st_ff.wreg == REG_W'($past(sel_byte) + BYTE_ONE)
        && cur_byte == $past(sel_byte))
    else $error("increment to working register wrong");

  chk_halt_stop: assert property (
    st_ff.flg.halted && !(wr_take && av_req.address == ADDR_WAKE)
    && !(wr_take && (av_req.address != ADDR_CMD))
    |=> st_ff.flg.halted && !sys_clk_en && $stable(st_ff.wreg)
        && $stable(st_ff.mem) && $stable(st_ff.flg))
    else $error("core changed state while powered down");

  chk_halt_wdog: assert property (
    exec_go && exec_op == op_power_down
    |=> st_ff.pre == '0 && st_ff.cnt == '0
        ##1 (st_ff.pre == '0 || !st_ff.flg.halted))
    else $error("watchdog not cleared by power-down");

  chk_halt_flags: assert property (
    exec_go && exec_op == op_power_down
    |=> st_ff.flg.slp && !st_ff.flg.wdx && $stable(st_ff.flg.z)
        && $stable(st_ff.flg.c) && $stable(st_ff.flg.lnc))
    else $error("power-down flag update wrong");

  chk_zero_flag: assert property (
    is_zop |=> st_ff.flg.z == ($past(res.value) == BYTE_ZERO)
               && $stable(st_ff.flg.c))
    else $error("zero flag does not match result");

  cov_bcd_both: cover property (
    exec_go && exec_op == op_bcd_fixup_to_memory
    && bcd_adj == (BCD_ADJ_HI | BCD_ADJ_LO));
  cov_inc_wrap: cover property (
    exec_go && exec_op == op_memory_plus_one && sel_byte == 8'hFF);
  cov_halt_wake: cover property (
    exec_go && exec_op == op_power_down ##[1:50] !st_ff.flg.halted);

endmodule

`default_nettype wire

/* dv/incdec_bcd_unit_tb.sv */
// Self-checking bench for the BCD, inc/dec and power-down unit
`timescale 1ns/10ps
`default_nettype none

module incdec_bcd_unit_tb import bcd_alu_pkg::*;;
  logic        clk;        // 100 MHz clock
  logic        nrst;       // Sync reset, active low
  av_req_t     req;        // Bus request
  av_rsp_t     rsp;        // Bus response
  logic        clk_en;     // Core clock running
  logic [7:0]  wreg;       // Working register
  flags_t      status;     // Flags
  int          failures;   // Mismatch count
  int          checks;     // Comparison count
  logic [15:0] q;          // Last read data
  logic [20:0] e;          // Expected mem, wreg, flags
  logic [7:0]  m;          // Stimulus byte
  logic [7:0]  w;          // Stimulus working register
  logic [4:0]  f;          // Stimulus flags
  logic [3:0]  idx;        // Memory index
  logic [2:0]  op;         // Opcode
  logic [7:0]  ma;         // Memory byte address

  incdec_bcd_unit i_incdec_bcd_unit (.clk(clk), .nrst(nrst), .av_req(req),
    .av_rsp(rsp), .sys_clk_en(clk_en), .working_reg(wreg), .status(status));

  // ==========================================================
  // Clock and watchdog
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // About 3850 cycles are needed; cut the run at 20000
  initial begin
    #200_000;
    failures++;
    $display("[FAIL] run_end exp done got timeout");
    complete_run();
  end

  // ==========================================================
  // Bus tasks
  // ==========================================================
  // Hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic is_wr, input logic [7:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req.read <= ~is_wr;
    req.write <= is_wr;
    req.address <= a;
    req.writedata <= {24'h000000, d};
    req.byteenable <= 4'hF;
    @(posedge clk);
    while (rsp.waitrequest !== 1'b0 && n < 64) begin
      @(posedge clk);
      n++;
    end
    q = rsp.readdata[15:0];
    if (n == 64) begin
      failures++;
      $display("[FAIL] waitrequest exp 0 got 1");
    end
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic cmp(input string what, input logic [7:0] ex,
                     input logic [7:0] got);
    checks++;
    if (got !== ex) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", what, ex, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ex, string nm);
    bus(1'b0, a, 8'h00);
    cmp(nm, ex, q[7:0]);
  endtask

  // ==========================================================
  // Expectation: returns {memory, working reg, flags 4:0}
  // ==========================================================
  function automatic logic [20:0] model(input logic [2:0] o,
    input logic [7:0] mb, input logic [7:0] wb, input logic [4:0] fl);
    logic [7:0] r;
    logic [8:0] s;
    logic       lo;
    logic       hi;
    logic [7:0] nm;
    logic [7:0] nw;
    logic [4:0] nf;
    nm = mb;
    nw = wb;
    nf = fl;
    // No-op command leaves every byte and flag alone
    if (o == 3'h0) return {nm, nw, nf};
    r = (o == 3'h1) ? ~mb : (o == 3'h3 || o == 3'h4) ? mb - 8'h01 : mb + 8'h01;
    if (o == 3'h2) begin
      // Both nibble tests look at the uncorrected value
      lo = (wb[3:0] > 4'h9) || fl[2];
      hi = (wb[7:4] > 4'h9) || fl[1];
      s = {1'b0, wb} + {1'b0, hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
      nm = s[7:0];
      nf[1] = fl[1] | hi | s[8];
    end else begin
      nf[0] = (r == 8'h00);
      if (o == 3'h3 || o == 3'h5) nm = r;
      else nw = r;
    end
    return {nm, nw, nf};
  endfunction

  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    req = '0;
    nrst = 1'b0;
    failures = 0;
    checks = 0;
    void'($urandom(89));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(ADDR_WREG, 8'h00, "wreg_reset");
    rd(ADDR_STAT, 8'h00, "status_reset");
    rd(8'h30, 8'h00, "unmapped");
    $display("test reset done");
    // Random operands, corner bytes 00/FF/99 in the first passes
    for (int i = 0; i < 180; i++) begin
      op = 3'($urandom % 7);
      idx = 4'($urandom);
      m = (i < 12) ? ((i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'hFF : 8'h01)
                   : 8'($urandom);
      w = (i < 12) ? ((i % 2 == 0) ? 8'h99 : 8'h9A) : 8'($urandom);
      f = 5'($urandom);
      ma = ADDR_MEM + {2'h0, idx, 2'h0};
      wr(ma, m);
      wr(ADDR_WREG, w);
      wr(ADDR_STAT, {3'h0, f});
      wr(ADDR_CMD, {idx, 1'b0, op});
      e = model(op, m, w, f);
      rd(ma, e[20:13], "mem");
      rd(ADDR_WREG, e[12:5], "wreg");
      rd(ADDR_STAT, {3'h0, e[4:0]}, "flags");
      cmp("wreg_port", e[12:5], wreg);
      cmp("status_port", {3'h0, e[4:0]}, {2'h0, status});
    end
    $display("test random_ops done");
    // Power-down with expired flag preset
    wr(ADDR_MEM + 8'h0C, 8'h5A);
    wr(ADDR_WREG, 8'hA5);
    wr(ADDR_STAT, 8'h17);
    wr(ADDR_CMD, 8'h37);
    // The halt lands on the write edge; look one edge later
    @(posedge clk);
    cmp("clk_en_halt", 8'h00, {7'h00, clk_en});
    rd(ADDR_STAT, 8'h2F, "flags_halt");
    rd(ADDR_WDOG, 8'h00, "wdog_pre");
    cmp("wdog_cnt", 8'h00, q[15:8]);
    rd(ADDR_MEM + 8'h0C, 8'h5A, "mem_halt");
    rd(ADDR_WREG, 8'hA5, "wreg_halt");
    // Commands while halted must not execute
    wr(ADDR_CMD, 8'h35);
    rd(ADDR_MEM + 8'h0C, 8'h5A, "mem_refused");
    rd(ADDR_CMD, 8'h37, "cmd_refused");
    wr(ADDR_WAKE, 8'h01);
    @(posedge clk);
    cmp("clk_en_wake", 8'h01, {7'h00, clk_en});
    $display("test power_down done");
    complete_run();
  end
endmodule

`default_nettype wire
